// ===== pkg/pmal_pkg.sv
// Package of constants for the position-mode auxiliary logic.
package pmal_pkg;
    // APB register byte offsets.
    localparam logic [7:0] OFS_FDIV_CTRL = 8'h00;
    localparam logic [7:0] OFS_PPR = 8'h04;
    localparam logic [7:0] OFS_FLAG_CTRL = 8'h08;
    localparam logic [7:0] OFS_DONE_TH = 8'h0C;
    localparam logic [7:0] OFS_APPR_TH = 8'h10;
    localparam logic [7:0] OFS_WINDOW = 8'h14;
    localparam logic [7:0] OFS_HOLD = 8'h18;
    localparam logic [7:0] OFS_INT_SPEED = 8'h1C;
    localparam logic [7:0] OFS_INT_DIST = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    // Field positions in the control registers.
    localparam int SRC_LSB = 0;
    localparam int PHASE_BIT = 2;
    localparam int POL_LSB = 3;
    localparam int COND_LSB = 0;
    localparam int LOCK_BIT = 2;
    // Values after reset.
    localparam logic [19:0] PPR_RST = 20'h0_2710;
    localparam logic [31:0] DONE_TH_RST = 32'h0000_0007;
    localparam logic [31:0] APPR_TH_RST = 32'h0000_FFFF;
    localparam logic [15:0] WINDOW_RST = 16'h0001;
    localparam logic [15:0] HOLD_RST = 16'h0000;
    localparam logic [12:0] INT_SPEED_RST = 13'h0000;
    localparam logic [31:0] INT_DIST_RST = 32'h0001_0000;
    // Pulse source codes and flag conditions.
    localparam logic [1:0] SRC_ENCODER = 2'h0;
    localparam logic [1:0] SRC_REFERENCE = 2'h3;
    localparam logic [1:0] COND_LEVEL = 2'h0;
    // Encoder counts per motor revolution.
    localparam logic [31:0] ENC_RES = 32'h0002_0000;
    localparam logic [16:0] ENC_LAST = 17'h1_FFFF;
    // Least pre-trigger speed for speed setting 0, in rpm.
    localparam logic [15:0] MIN_INT_RPM = 16'h000A;
    // Timing: clock period and output pulse limits.
    localparam int CLK_NS = 100;
    localparam int OC_MAX_KPPS = 200;
    localparam int OC_MIN_NS = 1000000 / OC_MAX_KPPS;
    localparam int OC_GAP_CYC = (OC_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC = MS_NS / CLK_NS;
    // Interrupt positioning states.
    typedef enum logic [2:0] {
        INT_IDLE = 3'b001,
        INT_RUN = 3'b010,
        INT_LOCK = 3'b100
    } pmal_int_e;
endpackage : pmal_pkg

// ===== tb/pmal_host_model.sv
// Host-side feedback model for the drive.
`timescale 1ns/1ns
module pmal_host_model (
    // Clock and enable.
    input wire logic pclk,
    input wire logic run,
    input wire logic dir,
    // Encoder feedback.
    output logic enc_step,
    output logic enc_dir
);
    // Direction is a level chosen by the host; 1 runs the axis in reverse.
    // Counts on every other cycle, so steps are never back to back.
    always_ff @(posedge pclk) enc_step <= run & ~enc_step;
    assign enc_dir = dir;
endmodule : pmal_host_model

// ===== tb/testbench.sv
// Self-checking bench for the position-mode auxiliary logic.
`timescale 1ns/1ns
module testbench import pmal_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, enc_step, enc_dir, hrun, hdir;
    logic ref_step, ref_dir, pos_ref_valid, servo_on, position_mode, homing_active, er;
    logic home_trigger, fast_input_seven, interrupt_inhibit_used, interrupt_inhibit_in;
    logic interrupt_cancel_in, interrupt_enable_in, phase_a_out, phase_b_out, int_dir;
    logic index_diff_out, index_oc_out, pos_done_flag, approach_flag, interrupt_done_flag;
    logic int_run, ref_accept, home_start;
    logic [7:0] paddr;
    logic [15:0] motor_speed, int_speed;
    logic [31:0] pwdata, prdata, rd;
    logic signed [31:0] pos_deviation;
    int mismatches, num_checks, cyc;
    pmal_top #(.MS_TICK_CYC(10)) dut_u (.*);
    pmal_host_model host_u (.pclk(pclk), .run(hrun), .dir(hdir), .enc_step(enc_step),
        .enc_dir(enc_dir));
    // Clock and a watchdog that ends a hung run.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One APB transfer; waits on pready, so no fixed latency is assumed.
    task automatic apb(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        repeat (2) @(posedge pclk);
    endtask : apb
    // One-cycle pulses on trigger, reference step and new reference.
    task automatic kick(input logic [2:0] m);
        {fast_input_seven, ref_step, pos_ref_valid} <= m;
        @(posedge pclk);
        {fast_input_seven, ref_step, pos_ref_valid} <= 3'b000;
        @(posedge pclk);
    endtask : kick
    function automatic logic [1:0] gray(input int k);
        return {k[1] ^ k[0], k[1]};
    endfunction : gray
    initial begin
        {psel, penable, pwrite, paddr, pwdata, hrun, hdir, ref_step, ref_dir, presetn} = '0;
        {servo_on, position_mode, homing_active, home_trigger, fast_input_seven} = '0;
        {interrupt_inhibit_used, interrupt_inhibit_in, interrupt_cancel_in} = '0;
        {interrupt_enable_in, motor_speed, pos_deviation, pos_ref_valid} = '0;
        void'($urandom(32'hc9b06f1f));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        {servo_on, position_mode} <= 2'b11;
        pos_deviation <= 32'($urandom_range(14)) - 32'd7;
        apb(OFS_FLAG_CTRL, 32'h0000_0004);
        apb(OFS_PPR, 32'h0000_0000, 1'b0);
        chk("ppr", 32'(PPR_RST), rd);
        chk("flags", 3, {pos_done_flag, approach_flag});
        pos_deviation <= 32'h0000_0064;
        apb(8'h40, 32'h0000_0000);
        chk("hold", 3, {er, pos_done_flag});
        kick(3'b001);
        chk("relax", 0, pos_done_flag);
        servo_on <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("off", 0, {pos_done_flag, approach_flag});
        servo_on <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            apb(OFS_FDIV_CTRL, 32'(SRC_REFERENCE) | 32'(p << PHASE_BIT)
                | 32'((p + 1) << POL_LSB));
            chk("pol", 32'(p + 1), {index_diff_out, index_oc_out});
            for (int i = 1; i < 5; i++) begin
                kick(3'b010);
                chk("ab", 32'(gray(p ? -i : i)), {phase_a_out, phase_b_out});
            end
        end
        apb(OFS_INT_DIST, 32'h0000_0014);
        apb(OFS_INT_DIST, 32'h0000_0000, 1'b0);
        chk("dist", 32'h0000_0014, rd);
        motor_speed <= 16'(MIN_INT_RPM + $urandom_range(999));
        {interrupt_enable_in, interrupt_inhibit_used, interrupt_inhibit_in} <= 3'b111;
        kick(3'b100);
        chk("inhibit", 0, int_run);
        {homing_active, interrupt_inhibit_in, hrun} <= 3'b101;
        kick(3'b100);
        chk("homing", 0, int_run);
        {homing_active, home_trigger} <= 2'b01;
        kick(3'b100);
        kick(3'b001);
        chk("run", 8, {int_run, int_dir, ref_accept, home_start});
        chk("speed", 32'(motor_speed), 32'(int_speed));
        home_trigger <= 1'b0;
        for (int t = 0; t < 200 && interrupt_done_flag !== 1'b1; t++) @(posedge pclk);
        chk("idone", 3, {interrupt_done_flag, pos_done_flag});
        kick(3'b001);
        chk("lock", 0, ref_accept);
        interrupt_cancel_in <= 1'b1;
        repeat (2) @(posedge pclk);
        interrupt_cancel_in <= 1'b0;
        kick(3'b001);
        chk("cancel", 1, ref_accept);
        // one Gray step per count; a reverse start wraps the revolution.
        hrun <= 1'b0;
        apb(OFS_PPR, 32'h0000_8000);
        apb(OFS_FDIV_CTRL, 32'(SRC_ENCODER));
        for (int s = 0; s < 2; s++) begin
            {hdir, hrun} <= 2'b11;
            repeat (4) @(posedge pclk);
            hrun <= 1'b0;
            @(posedge pclk);
            chk("enc", s ? 0 : 15,
                {phase_a_out, phase_b_out, index_diff_out, index_oc_out});
        end
        summarize();
    end
endmodule : testbench

// ===== verilog/pmal_top.sv
// Frequency-division output, positioning flags and interrupt positioning.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Source 0 divides encoder counts into pulses_per_rev A/B pulses per revolution.
// - Encoder mode gives one index pulse per revolution, aligned with and as wide as A.
// - Phase select 0: A leads B forward, lags reverse; select 1 inverts it.
// - Differential outputs stay under 4 Mpps, open-collector index under 200 kpps.
// - Index polarity select sets differential and open-collector polarities independently.
// - Done flag asserts when deviation meets the done threshold in position mode.
// - Approach flag asserts when deviation meets the approach threshold.
// - Hold time 0 keeps the done flag until the next position reference.
// - Servo disabled forces the done and approach flags inactive.
// - A trigger runs the preset distance in the pre-trigger direction.
// - During a run all references, repeated triggers included, are dropped.
// - After the run the lock setting keeps references blocked or reopens them.
// - Run end raises the interrupt-done flag regardless of servo and trigger, and the done flag only while servo is on.
// - A trigger is honoured only if inhibit is unassigned or inactive.
// - Active cancel clears the lock and reopens references.
// - No run starts while homing is in progress.
// - Speed setting 0 uses pre-trigger speed if at least 10 rpm, else none.
// - The enable input permits or disables interrupt positioning.
// - Homing triggers are ignored during a run.
module pmal_top
    import pmal_pkg::*;
#(
    parameter int MS_TICK_CYC = MS_CYC
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Motion feedback and reference pulses.
    input wire logic enc_step,
    input wire logic enc_dir,
    input wire logic ref_step,
    input wire logic ref_dir,
    input wire logic pos_ref_valid,
    input wire logic signed [31:0] pos_deviation,
    input wire logic [15:0] motor_speed,
    // Drive state and discrete inputs.
    input wire logic servo_on,
    input wire logic position_mode,
    input wire logic homing_active,
    input wire logic home_trigger,
    input wire logic fast_input_seven,
    input wire logic interrupt_inhibit_used,
    input wire logic interrupt_inhibit_in,
    input wire logic interrupt_cancel_in,
    input wire logic interrupt_enable_in,
    // Frequency-division outputs.
    output logic phase_a_out,
    output logic phase_b_out,
    output logic index_diff_out,
    output logic index_oc_out,
    // Flags and motion control outputs.
    output logic pos_done_flag,
    output logic approach_flag,
    output logic interrupt_done_flag,
    output logic int_run,
    output logic int_dir,
    output logic [15:0] int_speed,
    output logic ref_accept,
    output logic home_start
);
    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers and APB answer.
    logic [1:0] pulse_source_sel, next_pulse_source_sel;
    logic output_phase_sel, next_output_phase_sel;
    logic [1:0] index_polarity_sel, next_index_polarity_sel;
    logic [19:0] pulses_per_rev, next_pulses_per_rev;
    logic [1:0] flag_output_condition, next_flag_output_condition;
    logic post_interrupt_lock_sel, next_post_interrupt_lock_sel;
    logic [31:0] done_threshold, next_done_threshold;
    logic [31:0] approach_threshold, next_approach_threshold;
    logic [15:0] window_ms, next_window_ms, hold_ms, next_hold_ms;
    logic [12:0] interrupt_speed_sel, next_interrupt_speed_sel;
    logic [31:0] int_distance, next_int_distance;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    pmal_int_e state, next_state;

    // Decode of a byte offset into a known register.
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a <= OFS_STATUS) && (a[1:0] == 2'b00);
    endfunction : is_mapped

    // Setup phase prepares the answer so the access phase completes at once.
    always_comb begin
        next_pulse_source_sel = pulse_source_sel;
        next_output_phase_sel = output_phase_sel;
        next_index_polarity_sel = index_polarity_sel;
        next_pulses_per_rev = pulses_per_rev;
        next_flag_output_condition = flag_output_condition;
        next_post_interrupt_lock_sel = post_interrupt_lock_sel;
        next_done_threshold = done_threshold;
        next_approach_threshold = approach_threshold;
        next_window_ms = window_ms;
        next_hold_ms = hold_ms;
        next_interrupt_speed_sel = interrupt_speed_sel;
        next_int_distance = int_distance;
        next_pready = psel && !penable;
        next_pslverr = psel && !penable && !is_mapped(paddr);
        next_prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_FDIV_CTRL: next_prdata = {27'h0, index_polarity_sel,
                                              output_phase_sel, pulse_source_sel};
                OFS_PPR: next_prdata = {12'h000, pulses_per_rev};
                OFS_FLAG_CTRL: next_prdata = {29'h0, post_interrupt_lock_sel,
                                              flag_output_condition};
                OFS_DONE_TH: next_prdata = done_threshold;
                OFS_APPR_TH: next_prdata = approach_threshold;
                OFS_WINDOW: next_prdata = {16'h0000, window_ms};
                OFS_HOLD: next_prdata = {16'h0000, hold_ms};
                OFS_INT_SPEED: next_prdata = {19'h0, interrupt_speed_sel};
                OFS_INT_DIST: next_prdata = int_distance;
                OFS_STATUS: next_prdata = {26'h0, state, interrupt_done_flag,
                                           approach_flag, pos_done_flag};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        // Writes land only on the completing access edge.
        if (psel && penable && pready && pwrite) begin
            case (paddr)
                OFS_FDIV_CTRL: begin
                    next_pulse_source_sel = pwdata[SRC_LSB+:2];
                    next_output_phase_sel = pwdata[PHASE_BIT];
                    next_index_polarity_sel = pwdata[POL_LSB+:2];
                end
                OFS_PPR: next_pulses_per_rev = pwdata[19:0];
                OFS_FLAG_CTRL: begin
                    next_flag_output_condition = pwdata[COND_LSB+:2];
                    next_post_interrupt_lock_sel = pwdata[LOCK_BIT];
                end
                OFS_DONE_TH: next_done_threshold = pwdata;
                OFS_APPR_TH: next_approach_threshold = pwdata;
                OFS_WINDOW: next_window_ms = pwdata[15:0];
                OFS_HOLD: next_hold_ms = pwdata[15:0];
                OFS_INT_SPEED: next_interrupt_speed_sel = pwdata[12:0];
                OFS_INT_DIST: next_int_distance = pwdata;
                default: next_int_distance = int_distance;
            endcase
        end
    end

    // Register stage of the bus slave.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_source_sel <= SRC_ENCODER;
            output_phase_sel <= 1'b0;
            index_polarity_sel <= 2'h0;
            pulses_per_rev <= PPR_RST;
            flag_output_condition <= COND_LEVEL;
            post_interrupt_lock_sel <= 1'b0;
            done_threshold <= DONE_TH_RST;
            approach_threshold <= APPR_TH_RST;
            window_ms <= WINDOW_RST;
            hold_ms <= HOLD_RST;
            interrupt_speed_sel <= INT_SPEED_RST;
            int_distance <= INT_DIST_RST;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pulse_source_sel <= next_pulse_source_sel;
            output_phase_sel <= next_output_phase_sel;
            index_polarity_sel <= next_index_polarity_sel;
            pulses_per_rev <= next_pulses_per_rev;
            flag_output_condition <= next_flag_output_condition;
            post_interrupt_lock_sel <= next_post_interrupt_lock_sel;
            done_threshold <= next_done_threshold;
            approach_threshold <= next_approach_threshold;
            window_ms <= next_window_ms;
            hold_ms <= next_hold_ms;
            interrupt_speed_sel <= next_interrupt_speed_sel;
            int_distance <= next_int_distance;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frequency-division output.
    logic [31:0] div_acc, next_div_acc;
    logic [16:0] rev_pos, next_rev_pos;
    logic [1:0] gray, next_gray;
    logic idx_pend, next_idx_pend, idx_act, next_idx_act, oc_act, next_oc_act;
    logic [7:0] oc_gap, next_oc_gap;
    logic q_step, q_dir, a_new, wrap;
    logic next_a, next_b, next_zd, next_zo;

    always_comb begin
        next_div_acc = div_acc;
        next_rev_pos = rev_pos;
        next_idx_pend = idx_pend;
        q_step = 1'b0;
        q_dir = 1'b0;
        wrap = 1'b0;
        if (pulse_source_sel == SRC_ENCODER && enc_step) begin
            next_div_acc = div_acc + {10'h000, pulses_per_rev, 2'b00};
            if (next_div_acc >= ENC_RES) begin
                next_div_acc = next_div_acc - ENC_RES;
                q_step = 1'b1;
            end
            q_dir = enc_dir;
            next_rev_pos = enc_dir ? rev_pos - 17'h0_0001 : rev_pos + 17'h0_0001;
            wrap = enc_dir ? (rev_pos == 17'h0_0000) : (rev_pos == ENC_LAST);
        end else if (pulse_source_sel == SRC_REFERENCE && ref_step) begin
            q_step = 1'b1;
            q_dir = ref_dir;
        end
        // phase select flips the walk direction
        next_gray = gray;
        if (q_step) begin
            next_gray = (q_dir ^ output_phase_sel) ? gray - 2'h1 : gray + 2'h1;
        end
        // at most one quadrature edge per clock keeps under the pulse limit
        a_new = next_gray[1] ^ next_gray[0];
        // index opens on the next rising A and closes on its fall
        if (wrap) begin
            next_idx_pend = 1'b1;
        end
        next_idx_act = idx_act;
        if (pulse_source_sel != SRC_ENCODER) begin
            next_idx_pend = 1'b0;
            next_idx_act = 1'b0;
        end else if (next_idx_pend && a_new && !phase_a_out) begin
            next_idx_act = 1'b1;
            next_idx_pend = 1'b0;
        end else if (idx_act && !a_new) begin
            next_idx_act = 1'b0;
        end
        // open-collector index spaced by its own pulse-rate limit
        next_oc_gap = (oc_gap != 8'h00) ? oc_gap - 8'h01 : oc_gap;
        next_oc_act = next_idx_act && (oc_act || oc_gap == 8'h00);
        if (next_oc_act && !oc_act) begin
            next_oc_gap = 8'(OC_GAP_CYC);
        end
        next_a = a_new;
        next_b = next_gray[1];
        next_zd = next_idx_act ^ index_polarity_sel[1];
        next_zo = next_oc_act ^ index_polarity_sel[0];
    end

    // Quadrature state and pins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_acc <= 32'h0000_0000;
            rev_pos <= 17'h0_0000;
            gray <= 2'h0;
            idx_pend <= 1'b0;
            idx_act <= 1'b0;
            oc_act <= 1'b0;
            oc_gap <= 8'h00;
            phase_a_out <= 1'b0;
            phase_b_out <= 1'b0;
            index_diff_out <= 1'b0;
            index_oc_out <= 1'b0;
        end else begin
            div_acc <= next_div_acc;
            rev_pos <= next_rev_pos;
            gray <= next_gray;
            idx_pend <= next_idx_pend;
            idx_act <= next_idx_act;
            oc_act <= next_oc_act;
            oc_gap <= next_oc_gap;
            phase_a_out <= next_a;
            phase_b_out <= next_b;
            index_diff_out <= next_zd;
            index_oc_out <= next_zo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Positioning flags and interrupt positioning.
    logic [31:0] dev_abs, remain, next_remain;
    logic [15:0] ms_div, next_ms_div, quiet_ms, next_quiet_ms, hold_cnt, next_hold_cnt;
    logic [15:0] next_int_speed;
    logic ms_tick, meet, finish, trig_prev, trigger;
    logic next_done, next_appr, next_int_done, next_int_dir, next_accept, next_home;

    always_comb begin
        dev_abs = pos_deviation[31] ? 32'(-pos_deviation) : 32'(pos_deviation);
        ms_tick = (ms_div == 16'(MS_TICK_CYC - 1));
        next_ms_div = ms_tick ? 16'h0000 : ms_div + 16'h0001;
        next_quiet_ms = quiet_ms;
        if (pos_ref_valid) begin
            next_quiet_ms = 16'h0000;
        end else if (ms_tick && quiet_ms != 16'hFFFF) begin
            next_quiet_ms = quiet_ms + 16'h0001;
        end
        // completion needs threshold, plus quiet window unless level mode
        meet = position_mode && (dev_abs <= done_threshold)
            && (flag_output_condition == COND_LEVEL || quiet_ms >= window_ms);
        finish = (state == INT_RUN) && (remain == 32'h0000_0000);
        next_done = pos_done_flag;
        next_hold_cnt = hold_cnt;
        // servo off forces both flags low
        if (!servo_on) begin
            next_done = 1'b0;
            next_hold_cnt = 16'h0000;
        end else if (finish || (meet && !pos_done_flag)) begin
            // run end also marks positioning done
            next_done = 1'b1;
            next_hold_cnt = hold_ms;
        end else if (pos_done_flag && hold_ms == 16'h0000) begin
            // zero hold keeps the flag until a new reference
            next_done = !pos_ref_valid;
        end else if (pos_done_flag && hold_cnt != 16'h0000) begin
            next_hold_cnt = ms_tick ? hold_cnt - 16'h0001 : hold_cnt;
        end else begin
            next_done = meet;
        end
        next_appr = servo_on && position_mode && (dev_abs <= approach_threshold);
        // speed 0 needs at least the minimum pre-trigger speed
        trigger = fast_input_seven && !trig_prev && position_mode && servo_on
            && interrupt_enable_in && !(interrupt_inhibit_used && interrupt_inhibit_in)
            && !homing_active
            && (interrupt_speed_sel != 13'h0000 || motor_speed >= MIN_INT_RPM);
        next_state = state;
        next_remain = remain;
        next_int_done = interrupt_done_flag;
        next_int_dir = int_dir;
        next_int_speed = int_speed;
        case (state)
            INT_IDLE: begin
                if (trigger) begin
                    next_state = INT_RUN;
                    next_remain = int_distance;
                    next_int_dir = enc_dir;
                    next_int_done = 1'b0;
                    next_int_speed = (interrupt_speed_sel == 13'h0000) ? motor_speed
                        : {3'b000, interrupt_speed_sel};
                end
            end
            INT_RUN: begin
                // lock setting picks the state after the run
                if (finish) begin
                    next_state = post_interrupt_lock_sel ? INT_LOCK : INT_IDLE;
                    next_int_done = 1'b1;
                end else if (enc_step) begin
                    next_remain = remain - 32'h0000_0001;
                end
            end
            INT_LOCK: begin
                if (interrupt_cancel_in) begin
                    next_state = INT_IDLE;
                end
            end
            default: next_state = INT_IDLE;
        endcase
        next_accept = pos_ref_valid && (state == INT_IDLE);
        // homing trigger masked during a run
        next_home = home_trigger && (state != INT_RUN);
    end

    // Flag and sequencer registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_div <= 16'h0000;
            quiet_ms <= 16'h0000;
            hold_cnt <= 16'h0000;
            remain <= 32'h0000_0000;
            trig_prev <= 1'b0;
            state <= INT_IDLE;
            pos_done_flag <= 1'b0;
            approach_flag <= 1'b0;
            interrupt_done_flag <= 1'b0;
            int_run <= 1'b0;
            int_dir <= 1'b0;
            int_speed <= 16'h0000;
            ref_accept <= 1'b0;
            home_start <= 1'b0;
        end else begin
            ms_div <= next_ms_div;
            quiet_ms <= next_quiet_ms;
            hold_cnt <= next_hold_cnt;
            remain <= next_remain;
            trig_prev <= fast_input_seven;
            state <= next_state;
            pos_done_flag <= next_done;
            approach_flag <= next_appr;
            interrupt_done_flag <= next_int_done;
            int_run <= (next_state == INT_RUN);
            int_dir <= next_int_dir;
            int_speed <= next_int_speed;
            ref_accept <= next_accept;
            home_start <= next_home;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence run_ends;
        state == INT_RUN && remain == 32'h0000_0000;
    endsequence
    sequence idle_blocked;
        state == INT_IDLE && (homing_active || (interrupt_inhibit_used && interrupt_inhibit_in)
            || !interrupt_enable_in);
    endsequence
    quad_one_edge_a: assert property (
        $countones({phase_a_out, phase_b_out} ^ $past({phase_a_out, phase_b_out})) <= 1)
        else $error("both phases changed in one cycle");
    servo_off_a: assert property (!servo_on |=> !pos_done_flag && !approach_flag)
        else $error("flag active with servo off");
    run_done_a: assert property (run_ends and servo_on |=> interrupt_done_flag ##0 pos_done_flag)
        else $error("run end did not raise done flags");
    run_drop_a: assert property (state == INT_RUN |=> !ref_accept)
        else $error("reference passed during run");
    start_block_a: assert property (idle_blocked |=> state == INT_IDLE)
        else $error("run started while blocked");
    home_mask_a: assert property (state == INT_RUN |=> !home_start)
        else $error("homing started during run");
    cancel_lock_a: assert property (state == INT_LOCK && interrupt_cancel_in |=> state == INT_IDLE)
        else $error("cancel did not release lock");
    slow_speed_a: assert property (state == INT_IDLE && interrupt_speed_sel == 13'h0000
        && motor_speed < MIN_INT_RPM |=> state == INT_IDLE)
        else $error("run started below minimum speed");
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("access phase without ready");
    index_with_a_a: assert property ((idx_act || oc_act) |-> phase_a_out)
        else $error("index active while phase A low");
endmodule : pmal_top
